// file: pkg/hbd_consts.svh
`ifndef HBD_CONSTS_SVH
`define HBD_CONSTS_SVH
// register offsets (byte addresses on the 16-bit cpu bus)
`define HBD_PINCFG_OFS     7'h0e
`define HBD_DMA0_OFS       7'h10
`define HBD_DMA1_OFS       7'h12
`define HBD_FIFO_PORT0_OFS 7'h18
`define HBD_FIFO_PORT1_OFS 7'h1c
// field positions
`define HBD_DRV_BIT        15
`define HBD_IRQPOL_BIT     0
`define HBD_REQPOL_BIT     14
`define HBD_BURST_BIT      13
`define HBD_ACKPOL_BIT     10
`define HBD_FORM_HI        9
`define HBD_FORM_LO        7
// writable masks, unassigned bits read zero
`define HBD_PINCFG_MASK    16'h8001
`define HBD_DMA_MASK       16'h6780
`define HBD_RESET_VAL      16'h0000
// transfer-signal codes
`define HBD_FORM_ADDR      3'h0
`define HBD_FORM_ACK_STB   3'h2
`define HBD_FORM_ACK_ONLY  3'h3
`define HBD_FORM_SPLIT     3'h4
// buffer
`define HBD_FIFO_DEPTH     8
`define HBD_FIFO_AW        3
`endif

// file: pkg/hbd_pkg.sv
package hbd_pkg;
   typedef struct packed {
      logic        req_pol;
      logic        burst;
      logic        ack_pol;
      logic [2:0]  form;
   } hbd_dma_cfg_t;

   typedef struct packed {
      logic        cs_n;
      logic        rd_n;
      logic        wr_n;
      logic [6:0]  addr;
      logic [15:0] wdata;
   } hbd_cpu_bus_t;

   typedef enum logic [2:0] {
      HBD_IDLE  = 3'b001,
      HBD_REQ   = 3'b010,
      HBD_GAP   = 3'b100
   } hbd_req_state_t;
endpackage

// file: tb/hbd_dma_partner.sv
`timescale 1ns/100ps
// external dma controller answering one channel's request
module hbd_dma_partner (
   input  wire logic       clk_in,
   input  wire logic       rstn_in,
   input  wire logic       en_in,
   input  wire logic       req_in,
   input  wire logic       req_pol_in,
   input  wire logic       ack_pol_in,
   input  wire logic [2:0] form_in,
   input  wire logic [1:0] delay_in,
   output logic            ack_out,
   output logic            split_rd_n_out
);
   int n;
   // one handshake per request, then a gap so a stale request is not taken twice
   initial begin
      ack_out = 1'b1;
      split_rd_n_out = 1'b1;
      forever begin
         @(posedge clk_in);
         #10;
         ack_out = ~ack_pol_in;
         split_rd_n_out = 1'b1;
         if (rstn_in && en_in && req_in === req_pol_in && form_in != 3'h0) begin
            for (n = 0; n < delay_in; n++) begin
               @(posedge clk_in);
               #10;
            end
            ack_out = ack_pol_in;
            n = 0;
            // strobed form: ack held while the request stands
            while (form_in == 3'h2 && req_in === req_pol_in && n < 100) begin
               @(posedge clk_in);
               #10;
               n++;
            end
            @(posedge clk_in);
            #10 split_rd_n_out = form_in != 3'h4;
            @(posedge clk_in);
            #10 ack_out = ~ack_pol_in;
            split_rd_n_out = 1'b1;
            repeat (2) @(posedge clk_in);
         end
      end
   end
endmodule

// file: tb/host_bus_dma_signal_config_bench.sv
`timescale 1ns/100ps
`include "hbd_consts.svh"
module host_bus_dma_signal_config_bench;
   import hbd_pkg::*;
   logic         clk_in, rstn_in, irq_event_in, irq_out, drv, bu, ch, rp, ap, pa;
   logic [1:0]   ack, fv, fr, req, stb, en, srd, dly;
   logic [2:0]   form;
   logic [2:0]   codes[4] = '{`HBD_FORM_ADDR, `HBD_FORM_ACK_STB,
                              `HBD_FORM_ACK_ONLY, `HBD_FORM_SPLIT};
   logic [15:0]  rdata, fdata, drain, d, v, e, x;
   logic [15:0]  q[$];
   logic [31:0]  rs = 32'h0000_2c3e;
   hbd_cpu_bus_t cpu;
   int           error_cnt, checks, nstb, ndrop, i, k, n;

   hbd_host_port uut (.clk_in(clk_in), .rstn_in(rstn_in), .cpu_in(cpu), .rdata_out(rdata),
      .dma_acknowledge_in(ack), .split_data_bus_in(8'h00), .split_rd_n_in(srd[0] & srd[1]),
      .irq_event_in(irq_event_in), .fill_valid_in(fv), .fill_ready_out(fr),
      .fill_data_in(fdata), .dma_request_out(req), .irq_out(irq_out),
      .drive_strength_out(drv), .fifo_strobe_out(stb), .drain_data_out(drain));
   for (genvar g = 0; g < 2; g++) begin : dmac
      hbd_dma_partner p (.clk_in(clk_in), .rstn_in(rstn_in), .en_in(en[g]), .req_in(req[g]),
         .req_pol_in(rp), .ack_pol_in(ap), .form_in(form), .delay_in(dly),
         .ack_out(ack[g]), .split_rd_n_out(srd[g]));
   end

   function automatic logic [15:0] rnd();
      rs ^= rs << 13;
      rs ^= rs >> 17;
      rs ^= rs << 5;
      return rs[15:0];
   endfunction
   // only legal signal codes, so reserved ones never reach the register
   function automatic logic [15:0] legal(input logic [15:0] r);
      r[9:7] = codes[r[1:0]];
      return r;
   endfunction
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic give_verdict();
      if (error_cnt == 0 && checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic wr(input logic [6:0] a, input logic [15:0] w);
      @(posedge clk_in);
      #10 cpu = '{1'b0, 1'b1, 1'b0, a, w};
      @(posedge clk_in);
      #10 cpu = '{1'b1, 1'b1, 1'b1, a, w};
   endtask
   task automatic rd(input logic [6:0] a, output logic [15:0] r);
      @(posedge clk_in);
      #10 cpu = '{1'b0, 1'b0, 1'b1, a, 16'h0000};
      @(posedge clk_in);
      #10 cpu = '{1'b1, 1'b1, 1'b1, a, 16'h0000};
      r = rdata;
   endtask

   initial begin
      clk_in = 1'b0;
      forever #50 clk_in = ~clk_in;
   end
   // hang guard, runs far past the expected length
   initial begin
      #5000000;
      error_cnt++;
      give_verdict();
   end
   // drained words and request drops on the channel under test
   always @(posedge clk_in) begin
      if (rstn_in && stb[ch] === 1'b1) begin
         nstb++;
         x = (q.size() > 0) ? q.pop_front() : ~drain;
         if (form == `HBD_FORM_SPLIT) check("split", {8'h00, drain[7:0]}, {8'h00, x[7:0]});
         else check("drain", drain, x);
      end
      if (pa && req[ch] !== rp) ndrop++;
      pa = (req[ch] === rp);
   end

   initial begin
      rstn_in = 1'b0;
      irq_event_in = 1'b0;
      cpu = '{1'b1, 1'b1, 1'b1, 7'h00, 16'h0000};
      {fv, fdata, en, form, rp, ap, bu, ch, dly, pa} = '0;
      repeat (8) @(posedge clk_in);
      #10 rstn_in = 1'b1;
      check("req idle", {14'h0, req}, 16'h0003);
      check("irq idle", {15'h0, irq_out}, 16'h0001);
      rd(`HBD_PINCFG_OFS, e);
      check("pin reset", e, 16'h0000);
      rd(`HBD_DMA0_OFS, e);
      check("dma0 reset", e, 16'h0000);
      rd(`HBD_DMA1_OFS, e);
      check("dma1 reset", e, 16'h0000);
      // both irq levels and drive settings, unassigned bits written as ones
      for (i = 0; i < 4; i++) begin
         wr(`HBD_PINCFG_OFS, {i[1], 14'h3fff, i[0]});
         d = rnd();
         irq_event_in = d[0];
         repeat (2) @(posedge clk_in);
         #10 check("irq", {15'h0, irq_out}, {15'h0, ~(d[0] ^ i[0])});
         check("drive", {15'h0, drv}, {15'h0, i[1]});
         rd(`HBD_PINCFG_OFS, e);
         check("pin cfg", e, {i[1], 14'h0, i[0]});
      end
      // random configs, each channel must keep its own
      for (i = 0; i < 8; i++) begin
         d = legal(rnd());
         v = legal(rnd());
         // idle ack rests high, so codes 010 and 011 keep a low-active ack here
         d[`HBD_ACKPOL_BIT] = d[`HBD_ACKPOL_BIT] & ~d[`HBD_FORM_LO + 1];
         v[`HBD_ACKPOL_BIT] = v[`HBD_ACKPOL_BIT] & ~v[`HBD_FORM_LO + 1];
         wr(`HBD_DMA0_OFS, d);
         wr(`HBD_DMA1_OFS, v);
         rd(`HBD_DMA0_OFS, e);
         check("dma0", e, d & `HBD_DMA_MASK);
         rd(`HBD_DMA1_OFS, e);
         check("dma1", e, v & `HBD_DMA_MASK);
      end
      wr(7'h20, 16'hffff);
      rd(7'h20, e);
      check("unmapped", e, 16'h0000);
      wr(`HBD_DMA0_OFS, 16'h0000);
      wr(`HBD_DMA1_OFS, 16'h4000);
      repeat (2) @(posedge clk_in);
      #10 check("req pol", {14'h0, req}, 16'h0001);
      // every signal code in cycle-steal then burst, random channel and polarities
      for (i = 0; i < 8; i++) begin
         d = rnd();
         {dly, ap, rp, ch} = d[4:0];
         form = codes[i % 4];
         bu = i[2];
         // park on the address form first, so the ack settles under the new polarity
         wr(ch ? `HBD_DMA1_OFS : `HBD_DMA0_OFS,
            {1'b0, rp, bu, 2'b00, ap, `HBD_FORM_ADDR, 7'h00});
         wr(ch ? `HBD_DMA1_OFS : `HBD_DMA0_OFS, {1'b0, rp, bu, 2'b00, ap, form, 7'h00});
         q = {};
         for (k = 0; k < 9 && fr[ch] === 1'b1; k++) begin
            fdata = rnd();
            fv[ch] = 1'b1;
            q.push_back(fdata);
            @(posedge clk_in);
            #10;
         end
         fv = 2'b00;
         check("fill", 16'(k), 16'(`HBD_FIFO_DEPTH));
         nstb = 0;
         ndrop = 0;
         en[ch] = 1'b1;
         // strobed forms: this side issues the reads, address only in the plain form
         for (k = 0; k < 8 && form < 3'h3; k++) begin
            for (n = 0; n < 200 && (req[ch] !== rp || (form != 0 && ack[ch] !== ap)); n++) begin
               @(posedge clk_in);
               #10;
            end
            rd(form != 0 ? 7'h20 : ch ? `HBD_FIFO_PORT1_OFS : `HBD_FIFO_PORT0_OFS, e);
            check("port", e, (form == `HBD_FORM_ADDR) ? q[0] : 16'h0000);
            repeat (4) @(posedge clk_in);
            #10;
         end
         for (n = 0; n < 400 && nstb < 8; n++) @(posedge clk_in);
         repeat (6) @(posedge clk_in);
         #10 en = 2'b00;
         check("strobes", 16'(nstb), 16'h0008);
         check("drops", 16'(ndrop), bu ? 16'h0001 : 16'h0008);
         check("req end", {15'h0, req[ch]}, {15'h0, ~rp});
      end
      give_verdict();
   end
endmodule

// file: verilog/hbd_fifo.sv
`timescale 1ns/100ps
module hbd_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int AW    = 3
) (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic [WIDTH-1:0]      out_data_out,
   output logic [AW:0]           level_out
);
   // storage kept outside the state struct, no reset needed for data
   logic [WIDTH-1:0] mem [DEPTH];

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0]   cnt;
   } hbd_fifo_st_t;

   hbd_fifo_st_t st_ff, nxt_st;
   logic push, pop;

   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;
   assign in_ready_out  = (st_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid_out = (st_ff.cnt != '0);
   assign out_data_out  = mem[st_ff.rp];
   assign level_out     = st_ff.cnt;

   // pointer and count update
   always_comb begin
      nxt_st = st_ff;
      if (push) begin
         nxt_st.wp = st_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_st.rp = st_ff.rp + 1'b1;
      end
      nxt_st.cnt = st_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // write port
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[st_ff.wp] <= in_data_in;
      end
   end
endmodule

// file: verilog/hbd_host_port.sv
`timescale 1ns/100ps
`include "hbd_consts.svh"
// Functional notes
// - drive-strength select bit steers drive current of host-facing outputs.
// - interrupt output polarity follows the interrupt polarity bit.
// - two independent dma config registers, one per channel and fifo port.
// - burst bit 13: 0 cycle-steal, 1 burst.
// - transfer-signal field bits 9..7 picks which signals qualify fifo accesses.
// - code 000: fifo port address plus read/write strobe on cpu bus; only the read strobe qualifies here.
// - code 010: acknowledge plus read/write strobe, address ignored; only the read strobe qualifies here.
// - code 011: acknowledge alone qualifies access on cpu bus.
// - code 100: access on 8-bit split bus qualified by acknowledge.
// - request output active level set by request polarity bit, 0 low.
// - acknowledge input active level set by acknowledge polarity bit, 0 low.
// - cycle-steal: request drops for every single word accessed.
// - burst: request held until the last buffered word is accessed.
module hbd_host_port (
   input  wire logic                  clk_in,
   input  wire logic                  rstn_in,
   input  wire hbd_pkg::hbd_cpu_bus_t cpu_in,
   output logic [15:0]                rdata_out,
   input  wire logic [1:0]            dma_acknowledge_in,
   input  wire logic [7:0]            split_data_bus_in,
   input  wire logic                  split_rd_n_in,
   input  wire logic                  irq_event_in,
   input  wire logic [1:0]            fill_valid_in,
   output logic [1:0]                 fill_ready_out,
   input  wire logic [15:0]           fill_data_in,
   output logic [1:0]                 dma_request_out,
   output logic                       irq_out,
   output logic                       drive_strength_out,
   output logic [1:0]                 fifo_strobe_out,
   output logic [15:0]                drain_data_out
);
   import hbd_pkg::*;

   // whole block state in one struct
   typedef struct packed {
      logic                 drv;
      logic                 irq_pol;
      hbd_dma_cfg_t [1:0]   cfg;
      hbd_req_state_t [1:0] rs;
      logic [1:0]           req;
      logic                 irq;
      logic [15:0]          rdata;
      logic [1:0]           stb;
      logic [15:0]          ddata;
      logic [1:0]           ack_d;
      logic [1:0]           rd_d;
   } hbd_st_t;

   hbd_st_t st_ff, nxt_st;

   logic [1:0]  ack_act;
   logic [1:0]  access;
   logic [1:0]  f_valid;
   logic [15:0] f_data [2];
   logic [3:0]  f_level [2];
   logic        cpu_rd, cpu_wr;

   assign cpu_rd = !cpu_in.cs_n && !cpu_in.rd_n;
   assign cpu_wr = !cpu_in.cs_n && !cpu_in.wr_n;

   // per channel: polarity, access qualification and buffer
   for (genvar c = 0; c < 2; c++) begin : g_ch
      logic [6:0] port_ofs;
      logic       strobe;
      logic       fresh;
      assign port_ofs = (c == 0) ? `HBD_FIFO_PORT0_OFS : `HBD_FIFO_PORT1_OFS;
      assign ack_act[c] = dma_acknowledge_in[c] ~^ st_ff.cfg[c].ack_pol;
      // a strobe is taken once, on its leading edge
      assign strobe = cpu_rd && !st_ff.rd_d[c];
      assign fresh  = ack_act[c] && !st_ff.ack_d[c];
      always_comb begin
         case (st_ff.cfg[c].form)
            `HBD_FORM_ADDR:     access[c] = strobe && cpu_in.addr == port_ofs;
            `HBD_FORM_ACK_STB:  access[c] = strobe && ack_act[c];
            `HBD_FORM_ACK_ONLY: access[c] = fresh;
            `HBD_FORM_SPLIT:    access[c] = ack_act[c] && !split_rd_n_in
                                            && !st_ff.rd_d[c];
            default:            access[c] = 1'b0; // reserved codes never move data
         endcase
      end
      hbd_fifo #(
         .WIDTH (16),
         .DEPTH (`HBD_FIFO_DEPTH),
         .AW    (`HBD_FIFO_AW)
      ) u_fifo (
         .clk_in        (clk_in),
         .rstn_in       (rstn_in),
         .in_valid_in   (fill_valid_in[c]),
         .in_ready_out  (fill_ready_out[c]),
         .in_data_in    (fill_data_in),
         .out_valid_out (f_valid[c]),
         .out_ready_in  (access[c]),
         .out_data_out  (f_data[c]),
         .level_out     (f_level[c])
      );
   end

   // register access, request sequencing and pin levels
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack_d = ack_act;
      for (int c = 0; c < 2; c++) begin
         nxt_st.rd_d[c] = (st_ff.cfg[c].form == `HBD_FORM_SPLIT) ? !split_rd_n_in : cpu_rd;
      end
      // writes: only documented fields store, rest reads zero
      if (cpu_wr) begin
         case (cpu_in.addr)
            `HBD_PINCFG_OFS: begin
               nxt_st.drv     = cpu_in.wdata[`HBD_DRV_BIT];
               nxt_st.irq_pol = cpu_in.wdata[`HBD_IRQPOL_BIT];
            end
            `HBD_DMA0_OFS, `HBD_DMA1_OFS: begin
               for (int c = 0; c < 2; c++) begin
                  if (cpu_in.addr == ((c == 0) ? `HBD_DMA0_OFS : `HBD_DMA1_OFS)) begin
                     nxt_st.cfg[c].req_pol = cpu_in.wdata[`HBD_REQPOL_BIT];
                     nxt_st.cfg[c].burst   = cpu_in.wdata[`HBD_BURST_BIT];
                     nxt_st.cfg[c].ack_pol = cpu_in.wdata[`HBD_ACKPOL_BIT];
                     nxt_st.cfg[c].form    = cpu_in.wdata[`HBD_FORM_HI:`HBD_FORM_LO];
                  end
               end
            end
            default: ;
         endcase
      end
      // reads: unmapped and unassigned bits give zero
      nxt_st.rdata = `HBD_RESET_VAL;
      if (cpu_rd) begin
         case (cpu_in.addr)
            `HBD_PINCFG_OFS: begin
               nxt_st.rdata[`HBD_DRV_BIT]    = st_ff.drv;
               nxt_st.rdata[`HBD_IRQPOL_BIT] = st_ff.irq_pol;
            end
            `HBD_DMA0_OFS, `HBD_DMA1_OFS: begin
               for (int c = 0; c < 2; c++) begin
                  if (cpu_in.addr == ((c == 0) ? `HBD_DMA0_OFS : `HBD_DMA1_OFS)) begin
                     nxt_st.rdata[`HBD_REQPOL_BIT] = st_ff.cfg[c].req_pol;
                     nxt_st.rdata[`HBD_BURST_BIT]  = st_ff.cfg[c].burst;
                     nxt_st.rdata[`HBD_ACKPOL_BIT] = st_ff.cfg[c].ack_pol;
                     nxt_st.rdata[`HBD_FORM_HI:`HBD_FORM_LO] = st_ff.cfg[c].form;
                  end
               end
            end
            `HBD_FIFO_PORT0_OFS: if (st_ff.cfg[0].form == `HBD_FORM_ADDR) begin
               nxt_st.rdata = f_data[0];
            end
            `HBD_FIFO_PORT1_OFS: if (st_ff.cfg[1].form == `HBD_FORM_ADDR) begin
               nxt_st.rdata = f_data[1];
            end
            default: ;
         endcase
      end
      // request machine per channel
      nxt_st.stb = access;
      for (int c = 0; c < 2; c++) begin
         if (access[c]) begin
            nxt_st.ddata = (st_ff.cfg[c].form == `HBD_FORM_SPLIT) ?
                           {8'h00, f_data[c][7:0]} : f_data[c];
         end
         case (st_ff.rs[c])
            HBD_IDLE: if (f_valid[c]) begin
               nxt_st.rs[c] = HBD_REQ;
            end
            HBD_REQ: if (access[c]) begin
               // cycle-steal drops per word, burst only on the last one
               if (!st_ff.cfg[c].burst || f_level[c] == 4'h1) begin
                  nxt_st.rs[c] = HBD_GAP;
               end
            end
            HBD_GAP: if (!ack_act[c]) begin
               nxt_st.rs[c] = HBD_IDLE;
            end
            default: nxt_st.rs[c] = HBD_IDLE;
         endcase
         // polarity applied from the next config, so a change lands in the same cycle as the register write
         nxt_st.req[c] = (nxt_st.rs[c] == HBD_REQ) ~^ nxt_st.cfg[c].req_pol;
      end
      nxt_st.irq = irq_event_in ~^ nxt_st.irq_pol;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st_ff       <= '0;
         st_ff.rs[0] <= HBD_IDLE;
         st_ff.rs[1] <= HBD_IDLE;
         st_ff.req   <= 2'h3; // low-active inactive level
         st_ff.irq   <= 1'b1;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign rdata_out          = st_ff.rdata;
   assign dma_request_out    = st_ff.req;
   assign irq_out            = st_ff.irq;
   assign drive_strength_out = st_ff.drv;
   assign fifo_strobe_out    = st_ff.stb;
   assign drain_data_out     = st_ff.ddata;

   // checks
   a_irq_level: assert property (@(posedge clk_in) disable iff (!rstn_in)
      irq_out == ($past(irq_event_in) ~^ st_ff.irq_pol))
      else $error("irq level wrong");
   a_req_pol: assert property (@(posedge clk_in) disable iff (!rstn_in)
      dma_request_out[0] == ((st_ff.rs[0] == HBD_REQ) ~^ st_ff.cfg[0].req_pol))
      else $error("request polarity wrong");
   // cycle-steal take: one word leaves the buffer while the request stands
   sequence s_steal_take;
      st_ff.rs[0] == HBD_REQ && access[0] && !st_ff.cfg[0].burst;
   endsequence
   // request withdrawn at the pin, machine parked until the ack goes away
   sequence s_req_parked;
      st_ff.rs[0] == HBD_GAP && dma_request_out[0] == !st_ff.cfg[0].req_pol;
   endsequence
   a_steal_drop: assert property (@(posedge clk_in) disable iff (!rstn_in)
      s_steal_take |=> s_req_parked)
      else $error("cycle steal did not drop");
   a_burst_hold: assert property (@(posedge clk_in) disable iff (!rstn_in)
      st_ff.rs[0] == HBD_REQ && access[0] && st_ff.cfg[0].burst && f_level[0] > 4'h1
      |=> st_ff.rs[0] == HBD_REQ)
      else $error("burst dropped early");
   a_reserved_idle: assert property (@(posedge clk_in) disable iff (!rstn_in)
      st_ff.cfg[1].form inside {3'h1, 3'h5, 3'h6, 3'h7} |-> !access[1])
      else $error("reserved code moved data");
   a_ackonly_qual: assert property (@(posedge clk_in) disable iff (!rstn_in)
      st_ff.cfg[0].form == `HBD_FORM_ACK_ONLY && access[0] |-> ack_act[0])
      else $error("ack only without ack");
   a_cfg_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cpu_wr && cpu_in.addr == `HBD_DMA1_OFS
      |=> st_ff.cfg[1].burst == $past(cpu_in.wdata[`HBD_BURST_BIT]))
      else $error("config write lost");
   a_drv_write: assert property (@(posedge clk_in) disable iff (!rstn_in)
      cpu_wr && cpu_in.addr == `HBD_PINCFG_OFS
      |=> ##1 drive_strength_out == $past(cpu_in.wdata[`HBD_DRV_BIT], 2))
      else $error("drive strength not applied");
endmodule
